// [src/hdc_pkg.sv]
// Purpose: shared types for the disk controller board logic
// Assumes: nothing beyond the constants header
// Notes: encodings of the size/drive/head byte and the window state
`include "hdc_consts.svh"
package hdc_pkg;
	typedef enum {HDC_WIN_IDLE, HDC_WIN_OPEN, HDC_WIN_HOLD} hdc_win_e;
	typedef enum logic [1:0] {
		HDC_SZ_256 = 2'h0,
		HDC_SZ_512 = 2'h1,
		HDC_SZ_1024 = 2'h2,
		HDC_SZ_128 = 2'h3
	} hdc_size_e;
	typedef logic [9:0] hdc_cyl_t;
endpackage

// [src/hdc_consts.svh]
// Purpose: offsets, field positions and timing counts
// Assumes: 200 MHz system clock, 5 ns period
// Notes: times are kept in their own unit and converted
`ifndef HDC_CONSTS_SVH
`define HDC_CONSTS_SVH
// ****************************************
// Clock and timing
// ****************************************
`define HDC_CLK_PS 5000
`define HDC_WIN_NS 50
`define HDC_DLY_NS 60
`define HDC_TAP_NS 12
`define HDC_RST_US 10
`define HDC_WIN_CYC ((`HDC_WIN_NS * 1000) / `HDC_CLK_PS)
`define HDC_DLY_CYC ((`HDC_DLY_NS * 1000 + `HDC_CLK_PS - 1) / `HDC_CLK_PS)
`define HDC_TAP_CYC ((`HDC_TAP_NS * 1000 + `HDC_CLK_PS - 1) / `HDC_CLK_PS)
`define HDC_RST_CYC ((`HDC_RST_US * 1000000 + `HDC_CLK_PS - 1) / `HDC_CLK_PS)
// ****************************************
// Port addresses
// ****************************************
`define HDC_A_RESET 10'h26C
`define HDC_A_DATA 10'h270
`define HDC_A_PRECOMP 10'h272
`define HDC_A_COUNT 10'h274
`define HDC_A_SECTOR 10'h276
`define HDC_A_CYL_LO 10'h278
`define HDC_A_CYL_HI 10'h27A
`define HDC_A_SDH 10'h27C
`define HDC_A_STATUS 10'h27E
`define HDC_REG_BASE 6'h27
`define HDC_STAT_BUSY 7
`define HDC_STAT_ERR 0
`define HDC_ERR_MASK 8'hD6
`define HDC_SDH_MASK 8'h7F
`define HDC_CYLHI_MASK 8'h03
`endif

// [src/hdc_write_select.sv]
// Purpose: picks early, nominal or late write data from a tapped delay
// Assumes: write data sampled on the system clock
// Notes: taps in 15 ns steps (12 ns rounded up to 3 cycles) up to 75 ns, middle tap is nominal
`timescale 1ns/1ps
`include "hdc_consts.svh"
module hdc_write_select
	import hdc_pkg::*;
#(
	parameter int TAP_CYC = `HDC_TAP_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Controls
	input wire logic early_en,
	input wire logic late_en,
	input wire logic nominal_en,
	input wire logic wdata,
	// Result
	output logic wdata_out
);
	localparam int LEN = 5 * TAP_CYC + 1;
	logic [LEN-1:0] line_r;
	logic [LEN-1:0] line_nxt;
	logic out_r;
	logic out_nxt;

	always_comb begin
		line_nxt = {line_r[LEN-2:0], wdata};
		// Early takes the shortest copy, late the longest
		if (early_en)
			out_nxt = line_r[TAP_CYC];
		else if (late_en)
			out_nxt = line_r[3 * TAP_CYC];
		else if (nominal_en)
			out_nxt = line_r[2 * TAP_CYC];
		else
			out_nxt = line_r[2 * TAP_CYC];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_r <= '0;
			out_r <= 1'b0;
		end else begin
			line_r <= line_nxt;
			out_r <= out_nxt;
		end
	end

	assign wdata_out = out_r;

	chk_early_tap: assert property (@(posedge clk) disable iff (!rst_n)
		early_en |=> out_r == $past(line_r[TAP_CYC]))
		else $error("early copy not chosen");
	chk_nominal_tap: assert property (@(posedge clk) disable iff (!rst_n)
		(nominal_en && !early_en && !late_en)
		|=> out_r == $past(line_r[2 * TAP_CYC]))
		else $error("nominal copy not chosen");
endmodule

// [src/hdc_board.sv]
// Purpose: disk controller board clocks, phase detector, precomp, ports
// Assumes: host strobes are single cycle and synchronous to CLK
// Notes: analog loop and controller sequencing are outside this block
//
// Functional notes
// - Halve the 20 MHz oscillator into the 10 MHz double-rate clock; here CLK is the 200 MHz system clock, so 100 MHz.
// - Halve again into the 5 MHz square controller word clock; here a quarter of CLK, 50 MHz.
// - A data leading edge opens a compare window of about 50 ns; here wcnt_r never closes it, only delayed data or a VCO edge does.
// - Window closes on data delayed 60 ns or inverted VCO edge.
// - After both delayed data and VCO arrive, latches clear until next bit.
// - Delayed data first sets pump-up, asking a faster VCO.
// - Inverted VCO first sets pump-down, asking a slower VCO.
// - Assert reduced write current past the programmed precomp cylinder.
// - In precomp area write bits 12 ns early or late on request; here one 3-cycle tap, 15 ns.
// - With reduced current, register early/late on double-rate clock.
// - Without reduced current, assert only the nominal enable.
// - Enables pick one of three delay-line copies, 12 ns taps to 60; taps here are 3 cycles (15 ns), to 75 ns.
// - Phase input is write data under write gate, else read data.
// - Any access at 026CH gives a 10 us controller reset pulse.
// - Port 0270H moves bytes through the sector buffer.
// - Read of 0272H returns the error byte; bits 0, 3, 5 unused.
// - 027AH holds top two cylinder bits; other bits ignored.
// - Size/drive/head byte: bit 7 zero, size, drive, head fields.
// - Decode only even ports, eight registers 0270H to 027EH.
// - Busy reported while controller owns the buffer; host waits.
`timescale 1ns/1ps
`include "hdc_consts.svh"
module hdc_board
	import hdc_pkg::*;
#(
	parameter int RST_CYC = `HDC_RST_CYC,
	parameter int WIN_CYC = `HDC_WIN_CYC,
	parameter int DLY_CYC = `HDC_DLY_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Host port
	input wire logic [9:0] HOST_ADDR,
	input wire logic HOST_RD,
	input wire logic HOST_WR,
	input wire logic [7:0] HOST_WDATA,
	output logic [7:0] HOST_RDATA,
	// Controller core side
	input wire logic BUFFER_OWNER_SELECT_N,
	input wire logic [7:0] CORE_ERROR,
	input wire logic CORE_ERR_FLAG,
	input wire logic [7:0] BUF_RDATA,
	output logic [7:0] BUF_WDATA,
	output logic BUF_WR,
	output logic BUF_RD,
	output logic CMD_WR,
	output logic [7:0] CMD_DATA,
	output logic CONTROLLER_RESET,
	output logic WORD_CLOCK,
	output logic DOUBLE_RATE_CLOCK,
	// Drive data
	input wire logic HEAD_CYL_STEP_IN,
	input wire logic [9:0] HEAD_CYL,
	input wire logic EARLY,
	input wire logic LATE,
	input wire logic WRITE_GATE,
	input wire logic WRITE_DATA,
	input wire logic READ_DATA,
	input wire logic VCO_CLOCK,
	output logic REDUCED_WRITE_CURRENT,
	output logic DRIVE_WRITE_DATA,
	output logic PUMP_UP,
	output logic PUMP_DOWN,
	// Register contents to the core
	output logic [7:0] SECTOR_COUNT,
	output logic [7:0] SECTOR_NUMBER,
	output logic [9:0] CYLINDER,
	output logic [7:0] SIZE_DRIVE_HEAD
);
	// ****************************************
	// Clock dividers
	// ****************************************
	logic dr_r, dr_nxt, wc_r, wc_nxt;

	always_comb begin
		dr_nxt = ~dr_r;
		wc_nxt = dr_r ? ~wc_r : wc_r;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			dr_r <= 1'b0;
			wc_r <= 1'b0;
		end else begin
			dr_r <= dr_nxt;
			wc_r <= wc_nxt;
		end
	end

	// ****************************************
	// Phase comparator
	// ****************************************
	localparam int DLEN = DLY_CYC + 1;
	hdc_win_e win_r, win_nxt;
	logic [DLEN-1:0] dline_r, dline_nxt;
	logic in_r, in_nxt, vco_r, vco_nxt;
	logic up_r, up_nxt, dn_r, dn_nxt;
	logic seen_d_r, seen_d_nxt, seen_v_r, seen_v_nxt;
	logic [7:0] wcnt_r, wcnt_nxt;
	logic phase_in, data_rise, dly_rise, vco_fall;

	always_comb begin
		phase_in = WRITE_GATE ? WRITE_DATA : READ_DATA;
		data_rise = phase_in && !in_r;
		dly_rise = !dline_r[DLEN-1] && dline_r[DLEN-2];
		vco_fall = !VCO_CLOCK && vco_r;
		in_nxt = phase_in;
		vco_nxt = VCO_CLOCK;
		dline_nxt = {dline_r[DLEN-2:0], phase_in};
		win_nxt = win_r;
		wcnt_nxt = wcnt_r;
		seen_d_nxt = seen_d_r;
		seen_v_nxt = seen_v_r;
		up_nxt = 1'b0;
		dn_nxt = 1'b0;
		unique case (win_r)
			HDC_WIN_IDLE: begin
				if (data_rise) begin
					win_nxt = HDC_WIN_OPEN;
					wcnt_nxt = 8'h00;
					seen_d_nxt = 1'b0;
					seen_v_nxt = 1'b0;
				end
			end
			HDC_WIN_OPEN: begin
				if (wcnt_r < 8'(WIN_CYC))
					wcnt_nxt = wcnt_r + 8'h01;
				if (dly_rise && !seen_v_r)
					up_nxt = 1'b1;
				else if (vco_fall && !seen_d_r)
					dn_nxt = 1'b1;
				if (dly_rise || vco_fall)
					win_nxt = HDC_WIN_HOLD;
				seen_d_nxt = seen_d_r | dly_rise;
				seen_v_nxt = seen_v_r | vco_fall;
			end
			HDC_WIN_HOLD: begin
				seen_d_nxt = seen_d_r | dly_rise;
				seen_v_nxt = seen_v_r | vco_fall;
				if (seen_d_nxt && seen_v_nxt)
					win_nxt = HDC_WIN_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			win_r <= HDC_WIN_IDLE;
			dline_r <= '0;
			in_r <= 1'b0;
			vco_r <= 1'b0;
			up_r <= 1'b0;
			dn_r <= 1'b0;
			seen_d_r <= 1'b0;
			seen_v_r <= 1'b0;
			wcnt_r <= 8'h00;
		end else begin
			win_r <= win_nxt;
			dline_r <= dline_nxt;
			in_r <= in_nxt;
			vco_r <= vco_nxt;
			up_r <= up_nxt;
			dn_r <= dn_nxt;
			seen_d_r <= seen_d_nxt;
			seen_v_r <= seen_v_nxt;
			wcnt_r <= wcnt_nxt;
		end
	end

	// ****************************************
	// Write precompensation
	// ****************************************
	logic rwc_r, rwc_nxt, eld_r, eld_nxt, lld_r, lld_nxt, ne_r, ne_nxt;
	logic [7:0] precomp_r, precomp_nxt;

	always_comb begin
		rwc_nxt = rwc_r;
		if (HEAD_CYL_STEP_IN)
			rwc_nxt = {HEAD_CYL[9:2]} > precomp_r;
		eld_nxt = eld_r;
		lld_nxt = lld_r;
		if (!rwc_r) begin
			eld_nxt = 1'b0;
			lld_nxt = 1'b0;
		end else if (dr_r) begin
			eld_nxt = EARLY;
			lld_nxt = LATE;
		end
		ne_nxt = !rwc_r;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rwc_r <= 1'b0;
			eld_r <= 1'b0;
			lld_r <= 1'b0;
			ne_r <= 1'b1;
		end else begin
			rwc_r <= rwc_nxt;
			eld_r <= eld_nxt;
			lld_r <= lld_nxt;
			ne_r <= ne_nxt;
		end
	end

	hdc_write_select u_wsel (
		.clk(CLK),
		.rst_n(RST_N),
		.early_en(eld_r),
		.late_en(lld_r),
		.nominal_en(ne_r),
		.wdata(WRITE_DATA),
		.wdata_out(DRIVE_WRITE_DATA)
	);

	// ****************************************
	// Host ports
	// ****************************************
	logic [7:0] cnt_r, cnt_nxt, sec_r, sec_nxt, cyl_lo_r, cyl_lo_nxt;
	logic [7:0] cyl_hi_r, cyl_hi_nxt, sdh_r, sdh_nxt, rd_r, rd_nxt;
	logic [7:0] bwd_r, bwd_nxt, cmd_r, cmd_nxt;
	logic bwr_r, bwr_nxt, brd_r, brd_nxt, cwr_r, cwr_nxt;
	logic [31:0] rcnt_r, rcnt_nxt;
	logic rst_out_r, rst_out_nxt, busy, acc, sel;

	always_comb begin
		busy = !BUFFER_OWNER_SELECT_N;
		acc = HOST_RD || HOST_WR;
		sel = HOST_ADDR[9:4] == `HDC_REG_BASE && !HOST_ADDR[0];
		precomp_nxt = precomp_r;
		cnt_nxt = cnt_r;
		sec_nxt = sec_r;
		cyl_lo_nxt = cyl_lo_r;
		cyl_hi_nxt = cyl_hi_r;
		sdh_nxt = sdh_r;
		rd_nxt = rd_r;
		bwd_nxt = bwd_r;
		cmd_nxt = cmd_r;
		bwr_nxt = 1'b0;
		brd_nxt = 1'b0;
		cwr_nxt = 1'b0;
		rcnt_nxt = (rcnt_r != 32'h0) ? rcnt_r - 32'h1 : rcnt_r;
		if (acc && HOST_ADDR == `HDC_A_RESET)
			rcnt_nxt = 32'(RST_CYC);
		rst_out_nxt = rcnt_nxt != 32'h0;
		if (HOST_WR && sel && !busy) begin
			unique case (HOST_ADDR)
				`HDC_A_DATA: begin
					bwd_nxt = HOST_WDATA;
					bwr_nxt = 1'b1;
				end
				`HDC_A_PRECOMP: precomp_nxt = HOST_WDATA;
				`HDC_A_COUNT: cnt_nxt = HOST_WDATA;
				`HDC_A_SECTOR: sec_nxt = HOST_WDATA;
				`HDC_A_CYL_LO: cyl_lo_nxt = HOST_WDATA;
				`HDC_A_CYL_HI:
					cyl_hi_nxt = HOST_WDATA & `HDC_CYLHI_MASK;
				`HDC_A_SDH: sdh_nxt = HOST_WDATA & `HDC_SDH_MASK;
				`HDC_A_STATUS: begin
					cmd_nxt = HOST_WDATA;
					cwr_nxt = 1'b1;
				end
				default: ;
			endcase
		end
		if (HOST_RD) begin
			rd_nxt = 8'h00;
			if (sel && busy)
				rd_nxt[`HDC_STAT_BUSY] = 1'b1;
			else if (sel) begin
				unique case (HOST_ADDR)
					`HDC_A_DATA: begin
						rd_nxt = BUF_RDATA;
						brd_nxt = 1'b1;
					end
					`HDC_A_PRECOMP:
						rd_nxt = CORE_ERROR & `HDC_ERR_MASK;
					`HDC_A_COUNT: rd_nxt = cnt_r;
					`HDC_A_SECTOR: rd_nxt = sec_r;
					`HDC_A_CYL_LO: rd_nxt = cyl_lo_r;
					`HDC_A_CYL_HI: rd_nxt = cyl_hi_r;
					`HDC_A_SDH: rd_nxt = sdh_r;
					`HDC_A_STATUS:
						rd_nxt[`HDC_STAT_ERR] = CORE_ERR_FLAG;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			precomp_r <= 8'h00;
			cnt_r <= 8'h00;
			sec_r <= 8'h00;
			cyl_lo_r <= 8'h00;
			cyl_hi_r <= 8'h00;
			sdh_r <= 8'h00;
			rd_r <= 8'h00;
			bwd_r <= 8'h00;
			cmd_r <= 8'h00;
			bwr_r <= 1'b0;
			brd_r <= 1'b0;
			cwr_r <= 1'b0;
			rcnt_r <= 32'h0;
			rst_out_r <= 1'b0;
		end else begin
			precomp_r <= precomp_nxt;
			cnt_r <= cnt_nxt;
			sec_r <= sec_nxt;
			cyl_lo_r <= cyl_lo_nxt;
			cyl_hi_r <= cyl_hi_nxt;
			sdh_r <= sdh_nxt;
			rd_r <= rd_nxt;
			bwd_r <= bwd_nxt;
			cmd_r <= cmd_nxt;
			bwr_r <= bwr_nxt;
			brd_r <= brd_nxt;
			cwr_r <= cwr_nxt;
			rcnt_r <= rcnt_nxt;
			rst_out_r <= rst_out_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign DOUBLE_RATE_CLOCK = dr_r;
	assign WORD_CLOCK = wc_r;
	assign PUMP_UP = up_r;
	assign PUMP_DOWN = dn_r;
	assign REDUCED_WRITE_CURRENT = rwc_r;
	assign HOST_RDATA = rd_r;
	assign BUF_WDATA = bwd_r;
	assign BUF_WR = bwr_r;
	assign BUF_RD = brd_r;
	assign CMD_WR = cwr_r;
	assign CMD_DATA = cmd_r;
	assign CONTROLLER_RESET = rst_out_r;
	assign SECTOR_COUNT = cnt_r;
	assign SECTOR_NUMBER = sec_r;
	assign CYLINDER = {cyl_hi_r[1:0], cyl_lo_r};
	assign SIZE_DRIVE_HEAD = sdh_r;

	// ****************************************
	// Checks
	// ****************************************
	chk_dr_toggle: assert property (@(posedge CLK) disable iff (!RST_N)
		$past(RST_N) |-> dr_r != $past(dr_r))
		else $error("double-rate clock did not toggle");
	chk_word_clock: assert property (@(posedge CLK) disable iff (!RST_N)
		$changed(wc_r) |=> $stable(wc_r) ##1 $changed(wc_r))
		else $error("word clock not divided by four");
	chk_pump_excl: assert property (@(posedge CLK) disable iff (!RST_N)
		!(up_r && dn_r))
		else $error("pump up and down together");
	chk_up_cause: assert property (@(posedge CLK) disable iff (!RST_N)
		up_r |-> $past(win_r == HDC_WIN_OPEN && dly_rise))
		else $error("pump up without delayed data");
	chk_dn_cause: assert property (@(posedge CLK) disable iff (!RST_N)
		dn_r |-> $past(win_r == HDC_WIN_OPEN && vco_fall))
		else $error("pump down without vco edge");
	chk_ne_only: assert property (@(posedge CLK) disable iff (!RST_N)
		!rwc_r ##1 !rwc_r |-> ne_r && !eld_r ##0 !lld_r)
		else $error("nominal not sole enable");
	chk_reset_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
		HOST_RD && HOST_ADDR == `HDC_A_RESET |=> rst_out_r [*8])
		else $error("reset pulse missing");
	chk_cyl_hi: assert property (@(posedge CLK) disable iff (!RST_N)
		cyl_hi_r[7:2] == 6'h00)
		else $error("cylinder high bits leaked");
	chk_busy_read: assert property (@(posedge CLK) disable iff (!RST_N)
		HOST_RD && sel && busy |=> rd_r == 8'h80)
		else $error("busy not reported");
	cov_pump_up: cover property (@(posedge CLK) disable iff (!RST_N) up_r);
	cov_pump_dn: cover property (@(posedge CLK) disable iff (!RST_N) dn_r);
	cov_rwc: cover property (@(posedge CLK) disable iff (!RST_N) eld_r);
endmodule

// [testbench/hdc_far_model.sv]
// Purpose: far side model: drive read data, core write data and the VCO
// Assumes: bit_go is a one-cycle request from the bench
// Notes: VCO falling edge placed early or late to steer the detector
`timescale 1ns/1ps
module hdc_far_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Requests from the bench
	input wire logic bit_go,
	input wire logic to_wr,
	input wire logic slow_vco,
	input wire logic buf_rd,
	// Far side lines
	output logic read_data,
	output logic write_data,
	output logic vco_clock,
	output logic [7:0] buf_rdata
);
	logic [5:0] cnt_r;
	logic wr_r;
	logic slow_r;
	logic pulse;
	logic [5:0] fall_at;
	assign pulse = cnt_r >= 6'h01 && cnt_r <= 6'h04;
	assign fall_at = slow_r ? 6'h14 : 6'h04;
	// Data lines rest low between bits
	assign read_data = pulse & ~wr_r;
	assign write_data = pulse & wr_r;
	assign vco_clock = !(cnt_r >= fall_at && cnt_r < fall_at + 6'h04);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 6'h00;
			wr_r <= 1'b0;
			slow_r <= 1'b0;
			buf_rdata <= 8'hA5;
		end else begin
			if (bit_go) begin
				cnt_r <= 6'h01;
				wr_r <= to_wr;
				slow_r <= slow_vco;
			end else if (cnt_r != 6'h00 && cnt_r != 6'h3F) begin
				cnt_r <= cnt_r + 6'h01;
			end
			// Next buffer byte once the current one was taken
			if (buf_rd) begin
				buf_rdata <= buf_rdata - 8'h01;
			end
		end
	end
endmodule

// [testbench/tb.sv]
// Purpose: self-checking bench for the disk controller board logic
// Assumes: inputs change on the falling edge, reset pulse shortened
// Notes: host reads are checked from a queue by a separate monitor
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
$display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
	import hdc_pkg::*;
	localparam int RST_CYC = 20;
	logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, bos_n = 1'b1;
	logic cflag = 1'b0, step = 1'b0, early = 1'b0, late = 1'b0;
	logic write_gate = 1'b0, go = 1'b0, to_wr = 1'b0, slow = 1'b0;
	logic [9:0] addr = 10'h000, hcyl = 10'h000;
	logic [7:0] wd = 8'h00, cerr = 8'h00, brd, rdata, bwd, cdat;
	logic bwr, brdp, cwr, crst, wclk, drc, wdat, rdat, vco, reduced_write_current, dwd, pu, pdn;
	logic [7:0] scnt, snum, size_drive_head, e, m, d;
	logic [9:0] cyl;
	logic [7:0] v [5];
	logic [7:0] exp_q [$];
	logic [7:0] msk_q [$];
	logic rd_seen = 1'b0, pd, pw;
	logic [31:0] seed = 32'h6E15;
	int error_cnt = 0, comparisons = 0, dn, dn2, de, dl, n;
	hdc_board #(.RST_CYC(RST_CYC)) i_hdc_board (.CLK(clk), .RST_N(rst_n),
		.HOST_ADDR(addr), .HOST_RD(rd), .HOST_WR(wr), .HOST_WDATA(wd),
		.HOST_RDATA(rdata), .BUFFER_OWNER_SELECT_N(bos_n),
		.CORE_ERROR(cerr), .CORE_ERR_FLAG(cflag), .BUF_RDATA(brd),
		.BUF_WDATA(bwd), .BUF_WR(bwr), .BUF_RD(brdp), .CMD_WR(cwr),
		.CMD_DATA(cdat), .CONTROLLER_RESET(crst), .WORD_CLOCK(wclk),
		.DOUBLE_RATE_CLOCK(drc), .HEAD_CYL_STEP_IN(step), .HEAD_CYL(hcyl),
		.EARLY(early), .LATE(late), .WRITE_GATE(write_gate), .WRITE_DATA(wdat),
		.READ_DATA(rdat), .VCO_CLOCK(vco), .REDUCED_WRITE_CURRENT(reduced_write_current),
		.DRIVE_WRITE_DATA(dwd), .PUMP_UP(pu), .PUMP_DOWN(pdn),
		.SECTOR_COUNT(scnt), .SECTOR_NUMBER(snum), .CYLINDER(cyl),
		.SIZE_DRIVE_HEAD(size_drive_head));
	hdc_far_model i_hdc_far_model (.clk(clk), .rst_n(rst_n), .bit_go(go),
		.to_wr(to_wr), .slow_vco(slow), .buf_rd(brdp), .read_data(rdat),
		.write_data(wdat), .vco_clock(vco), .buf_rdata(brd));
	always #2.5 clk = ~clk;
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic host_wr(input logic [9:0] a, input logic [7:0] dv);
		@(negedge clk);
		addr = a;
		wd = dv;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	// A zero mask means the read result is not checked
	task automatic host_rd(input logic [9:0] a, input logic [7:0] ev,
		input logic [7:0] mv);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		exp_q.push_back(ev);
		msk_q.push_back(mv);
		@(negedge clk);
		rd = 1'b0;
	endtask
	task automatic phase_bit(input logic g, w, s, input int eu, ed);
		int nu, nd;
		nu = 0;
		nd = 0;
		@(negedge clk);
		write_gate = g;
		to_wr = w;
		slow = s;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		repeat (40) begin
			nu += (pu === 1'b1);
			nd += (pdn === 1'b1);
			@(negedge clk);
		end
		`CHK(nu, eu)
		`CHK(nd, ed)
	endtask
	task automatic wr_delay(output int dv);
		@(negedge clk);
		to_wr = 1'b1;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		dv = 0;
		while (dwd !== 1'b1 && dv < 60) begin
			@(negedge clk);
			dv++;
		end
		`CHK(dv < 60, 1'b1)
		repeat (30) @(negedge clk);
	endtask
	task automatic head_to(input logic [9:0] c, input logic ev);
		@(negedge clk);
		hcyl = c;
		step = 1'b1;
		@(negedge clk);
		step = 1'b0;
		for (n = 0; n < 10 && reduced_write_current !== ev; n++) @(negedge clk);
		`CHK(reduced_write_current, ev)
	endtask
	task automatic tally_and_finish();
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ****************************************
	// Read monitor and watchdog
	// ****************************************
	always @(posedge clk) rd_seen <= rd;
	always @(negedge clk) begin
		if (rd_seen && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			if (m != 8'h00) `CHK(rdata & m, e)
		end
	end
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		pd = drc;
		pw = wclk;
		n = 0;
		repeat (16) begin
			@(negedge clk);
			`CHK(drc, ~pd)
			n += (wclk !== pw);
			pd = drc;
			pw = wclk;
		end
		`CHK(n, 8)
		for (int i = 0; i < 4; i++) begin
			v[i] = rnd();
			host_wr(10'h274 + 10'(2 * i), v[i]);
		end
		`CHK(scnt, v[0])
		`CHK(snum, v[1])
		`CHK(cyl, {v[3][1:0], v[2]})
		host_rd(10'h274, v[0], 8'hFF);
		host_rd(10'h278, v[2], 8'hFF);
		host_rd(10'h27A, v[3] & 8'h03, 8'h03);
		for (int k = 0; k < 4; k++) begin
			d = {1'b1, 2'(k), 5'(rnd())};
			host_wr(10'h27C, d);
			`CHK(size_drive_head, d & 8'h7F)
		end
		cerr = rnd();
		host_rd(10'h272, cerr & 8'hD6, 8'hFF);
		bos_n = 1'b0;
		host_wr(10'h274, ~v[0]);
		`CHK(scnt, v[0])
		host_rd(10'h276, 8'h80, 8'hFF);
		host_rd(10'h27E, 8'h80, 8'h80);
		bos_n = 1'b1;
		cflag = 1'b1;
		host_rd(10'h27E, 8'h01, 8'h81);
		host_wr(10'h275, ~v[0]);
		`CHK(scnt, v[0])
		host_wr(10'h271, 8'h3C);
		`CHK(bwr, 1'b0)
		d = rnd();
		host_wr(10'h270, d);
		`CHK(bwr, 1'b1)
		`CHK(bwd, d)
		host_rd(10'h270, 8'hA5, 8'hFF);
		host_rd(10'h270, 8'hA4, 8'hFF);
		d = rnd();
		host_wr(10'h27E, d);
		`CHK(cwr, 1'b1)
		`CHK(cdat, d)
		phase_bit(1'b0, 1'b0, 1'b1, 1, 0);
		phase_bit(1'b0, 1'b0, 1'b0, 0, 1);
		phase_bit(1'b1, 1'b0, 1'b1, 0, 0);
		phase_bit(1'b1, 1'b1, 1'b1, 1, 0);
		phase_bit(1'b0, 1'b1, 1'b1, 0, 0);
		phase_bit(1'b1, 1'b1, 1'b0, 0, 1);
		write_gate = 1'b0;
		early = 1'b1;
		wr_delay(dn);
		early = 1'b0;
		late = 1'b1;
		wr_delay(dn2);
		`CHK(dn2, dn)
		host_wr(10'h272, 8'h02);
		head_to(10'h00C, 1'b1);
		wr_delay(dl);
		late = 1'b0;
		early = 1'b1;
		wr_delay(de);
		`CHK(de < dn, 1'b1)
		`CHK(dl > dn, 1'b1)
		head_to(10'h008, 1'b0);
		for (int k = 0; k < 2; k++) begin
			if (k == 0)
				host_wr(10'h26C, rnd());
			else
				host_rd(10'h26C, 8'h00, 8'h00);
			n = 0;
			while (crst === 1'b1 && n < 100) begin
				n++;
				@(negedge clk);
			end
			`CHK(n, RST_CYC)
		end
		repeat (3) @(negedge clk);
		tally_and_finish();
	end
endmodule
